// *** logic/rmts_sequencer.sv ***
// Purpose: trigger sequencer that steps stored setups onto the relay cards
// Assumes: card and bus logic run on mclk; only the trigger pin is asynchronous
// Notes: matrix-ready pin and poll byte follow the internal state by one edge
`timescale 1ns/10ps
module rmts_sequencer import rmts_pkg::*; #(
	parameter int NROWS = ROWS,
	parameter int NCOLS = COLS,
	parameter int DEPTH = SETUP_DEPTH,
	parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration and commands
	input wire rmts_cfg_t cfg,
	input wire logic delay_wr,
	input wire logic [DELAY_W-1:0] delay_ms_in,
	input wire rmts_row_cmd_t row_cmd,
	input wire logic err_clear,
	// Setup store loading
	input wire logic mem_wr_en,
	input wire logic [PTR_W-1:0] mem_wr_addr,
	input wire logic [NROWS*NCOLS-1:0] mem_wr_data,
	// Trigger inputs
	input wire logic bus_trigger,
	input wire logic external_trigger_pin,
	// Card and chain information seen at power-up
	input wire logic [DELAY_W-1:0] hw_settle_ms_in,
	input wire logic chain_err_in,
	// Relay card side
	output logic [NROWS*NCOLS-1:0] relay_setup_reg,
	output logic relay_load_reg,
	output logic [NROWS-1:0] mb_rows_reg,
	output logic [NROWS-1:0] bm_rows_reg,
	// Status
	output logic matrix_ready_pin_reg,
	output rmts_poll_t poll_status_reg,
	output rmts_err_t error_cause_query_reg,
	output logic [DELAY_W-1:0] machine_status_query_reg,
	output logic [DELAY_W-1:0] hw_settle_query_reg,
	output logic [PTR_W-1:0] step_ptr_reg,
	output logic standalone_reg
);

	localparam int SW = NROWS * NCOLS;
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [XFER_CNT_W-1:0] XFER_LAST = XFER_CNT_W'(XFER_CYCLES - 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_XFER,
		ST_HW_SETTLE,
		ST_PROG_SETTLE
	} rmts_state_t;

	// Phase ordering; a phase whose row group is empty is skipped
	function automatic logic [1:0] first_phase(input logic mb_any, input logic bm_any);
		return bm_any ? PH_BM_OPEN : (mb_any ? PH_MB_CLOSE : PH_FINAL);
	endfunction

	function automatic logic [1:0] next_phase(input logic [1:0] ph, input logic mb_any,
		input logic bm_any);
		case (ph)
			PH_BM_OPEN: return mb_any ? PH_MB_CLOSE : PH_FINAL;
			PH_MB_CLOSE: return bm_any ? PH_MB_OPEN : PH_FINAL;
			default: return PH_FINAL;
		endcase
	endfunction

	// Relay image for one phase, built from the present image and the target
	function automatic logic [SW-1:0] phase_setup(input logic [1:0] ph,
		input logic [SW-1:0] cur, input logic [SW-1:0] tgt,
		input logic [SW-1:0] mmask, input logic [SW-1:0] bmask);
		case (ph)
			PH_BM_OPEN: return cur & ~bmask;
			PH_MB_CLOSE: return cur | (tgt & mmask);
			PH_MB_OPEN: return (cur & ~mmask) | (tgt & mmask);
			default: return tgt;
		endcase
	endfunction

	rmts_state_t state_reg;
	logic [1:0] phase_reg;
	logic [SW-1:0] target_reg;
	logic [XFER_CNT_W-1:0] xfer_cnt_reg;
	logic [DELAY_W-1:0] settle_cnt_reg;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [DELAY_W-1:0] delay_reg;
	logic [DELAY_W-1:0] hw_settle_reg;
	logic init_done_reg;
	logic ready_reg;
	logic mready_reg;
	logic [SYNC_STAGES-1:0] ext_sync_reg;
	logic [1:0] ext_arm_reg;
	logic ext_level_reg;
	logic ext_agree;
	logic [SW-1:0] mb_mask;
	logic [SW-1:0] bm_mask;
	logic [SW-1:0] rd_data;
	logic mb_any;
	logic bm_any;
	logic ext_rise;
	logic ext_fall;
	logic trig;
	logic accept;
	logic overrun;
	logic not_settled;
	logic tick;
	logic settle_done;
	logic settle_start;
	logic [PTR_W-1:0] next_ptr;

	// Row masks spread over the columns of each row
	genvar gr;
	generate
		for (gr = 0; gr < NROWS; gr++) begin : g_mask
			assign mb_mask[gr*NCOLS +: NCOLS] = {NCOLS{mb_rows_reg[gr]}};
			assign bm_mask[gr*NCOLS +: NCOLS] = {NCOLS{bm_rows_reg[gr]}};
		end
	endgenerate

	assign mb_any = |mb_rows_reg;
	assign bm_any = |bm_rows_reg;

	// Pin level is learnt while arming, so leaving reset never fakes an edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_sync_reg <= '0;
			ext_arm_reg <= '0;
			ext_level_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[SYNC_STAGES-2:0], external_trigger_pin};
			if (ext_arm_reg != 2'(SYNC_STAGES)) begin
				ext_arm_reg <= ext_arm_reg + 2'h1;
				ext_level_reg <= ext_sync_reg[1];
			end else if (ext_agree) begin
				ext_level_reg <= ext_sync_reg[2];
			end
		end
	end

	assign ext_agree = (ext_sync_reg[1] == ext_sync_reg[2]) && (ext_arm_reg == 2'(SYNC_STAGES));
	assign ext_rise = ext_agree && ext_sync_reg[2] && !ext_level_reg;
	assign ext_fall = ext_agree && !ext_sync_reg[2] && ext_level_reg;

	always_comb begin
		if (cfg.src == TRIG_SRC_EXT) begin
			trig = cfg.ext_rising ? ext_rise : ext_fall;
		end else begin
			trig = bus_trigger;
		end
		trig = trig & cfg.trigger_enable_cmd & init_done_reg;
	end

	// Transfer in progress refuses; settling lets the trigger through
	assign overrun = trig && (state_reg == ST_FETCH || state_reg == ST_XFER);
	assign not_settled = trig && (state_reg == ST_HW_SETTLE || state_reg == ST_PROG_SETTLE);
	assign accept = trig && !overrun;
	assign next_ptr = (step_ptr_reg == PTR_LAST) ? PTR_RESET : step_ptr_reg + 7'h01;

	rmts_setup_mem #(.WIDTH(SW), .DEPTH(DEPTH), .AW(PTR_W)) u_mem (
		.mclk(mclk),
		.rst(rst),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_en(accept),
		.rd_addr(next_ptr),
		.rd_data(rd_data)
	);

	// Card settle time and chain state are caught once after reset release
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_done_reg <= 1'b0;
			hw_settle_reg <= '0;
			standalone_reg <= 1'b1;
		end else if (!init_done_reg) begin
			init_done_reg <= 1'b1;
			hw_settle_reg <= hw_settle_ms_in;
			standalone_reg <= chain_err_in;
		end
	end

	// Out-of-range values are dropped so the old delay stays in force
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			delay_reg <= DELAY_RESET_MS;
		end else if (delay_wr && delay_ms_in <= DELAY_MAX_MS) begin
			delay_reg <= delay_ms_in;
		end
	end

	// Row modes; a row never holds both; ports feed chained units
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mb_rows_reg <= '0;
			bm_rows_reg <= '0;
		end else if (row_cmd.valid && int'(row_cmd.row) < NROWS) begin
			case (row_cmd.op)
				ROW_SEL_MB: begin
					mb_rows_reg[row_cmd.row] <= 1'b1;
					bm_rows_reg[row_cmd.row] <= 1'b0;
				end
				ROW_SEL_BM: begin
					bm_rows_reg[row_cmd.row] <= 1'b1;
					mb_rows_reg[row_cmd.row] <= 1'b0;
				end
				ROW_DESEL_MB: mb_rows_reg[row_cmd.row] <= 1'b0;
				ROW_DESEL_BM: bm_rows_reg[row_cmd.row] <= 1'b0;
				default: mb_rows_reg <= mb_rows_reg;
			endcase
		end
	end

	// Tick restarts with each wait so a delay of N is never short of N ms
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= '0;
		end else if (settle_start || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end

	assign tick = (tick_cnt_reg == TICK_LAST);
	assign settle_done = (settle_cnt_reg == '0);
	assign settle_start = (state_reg == ST_XFER && xfer_cnt_reg == XFER_LAST)
		|| (state_reg == ST_HW_SETTLE && settle_done && phase_reg == PH_FINAL);

	// Sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_FINAL;
			target_reg <= '0;
			xfer_cnt_reg <= '0;
			settle_cnt_reg <= '0;
			relay_setup_reg <= '0;
			relay_load_reg <= 1'b0;
			step_ptr_reg <= PTR_RESET;
			ready_reg <= 1'b1;
			mready_reg <= 1'b0;
		end else begin
			relay_load_reg <= 1'b0;
			if (accept) begin
				state_reg <= ST_FETCH;
				step_ptr_reg <= next_ptr;
				ready_reg <= 1'b0;
				mready_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: state_reg <= ST_IDLE;
					ST_FETCH: begin
						target_reg <= rd_data;
						phase_reg <= first_phase(mb_any, bm_any);
						relay_setup_reg <= phase_setup(first_phase(mb_any, bm_any),
							relay_setup_reg, rd_data, mb_mask, bm_mask);
						relay_load_reg <= 1'b1;
						xfer_cnt_reg <= '0;
						state_reg <= ST_XFER;
					end
					ST_XFER: begin
						xfer_cnt_reg <= xfer_cnt_reg + 1'b1;
						if (xfer_cnt_reg == XFER_LAST) begin
							settle_cnt_reg <= hw_settle_reg;
							state_reg <= ST_HW_SETTLE;
						end
					end
					ST_HW_SETTLE: begin
						if (settle_done) begin
							if (phase_reg != PH_FINAL) begin
								// Another intermediate image costs another interval
								phase_reg <= next_phase(phase_reg, mb_any, bm_any);
								relay_setup_reg <= phase_setup(
									next_phase(phase_reg, mb_any, bm_any),
									relay_setup_reg, target_reg, mb_mask, bm_mask);
								relay_load_reg <= 1'b1;
								xfer_cnt_reg <= '0;
								state_reg <= ST_XFER;
							end else begin
								settle_cnt_reg <= delay_reg;
								state_reg <= ST_PROG_SETTLE;
							end
						end else if (tick) begin
							settle_cnt_reg <= settle_cnt_reg - 1'b1;
						end
					end
					ST_PROG_SETTLE: begin
						if (settle_done) begin
							ready_reg <= 1'b1;
							mready_reg <= 1'b1;
							state_reg <= ST_IDLE;
						end else if (tick) begin
							settle_cnt_reg <= settle_cnt_reg - 1'b1;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// Error causes are sticky; a new error beats a clear in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			error_cause_query_reg <= '0;
		end else begin
			if (overrun) begin
				error_cause_query_reg.overrun <= 1'b1;
			end else if (err_clear) begin
				error_cause_query_reg.overrun <= 1'b0;
			end
			if (not_settled) begin
				error_cause_query_reg.not_settled <= 1'b1;
			end else if (err_clear) begin
				error_cause_query_reg.not_settled <= 1'b0;
			end
		end
	end

	// Status outputs, all registered
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			matrix_ready_pin_reg <= 1'b1;
			poll_status_reg <= '0;
			machine_status_query_reg <= DELAY_RESET_MS;
			hw_settle_query_reg <= '0;
		end else begin
			matrix_ready_pin_reg <= cfg.mready_high ? mready_reg : ~mready_reg;
			poll_status_reg.ready <= ready_reg;
			poll_status_reg.matrix_ready <= mready_reg;
			poll_status_reg.err <= error_cause_query_reg.overrun
				| error_cause_query_reg.not_settled;
			machine_status_query_reg <= delay_reg;
			hw_settle_query_reg <= hw_settle_reg;
		end
	end

endmodule // rmts_sequencer

// *** logic/rmts_setup_mem.sv ***
// Purpose: store of relay setups, one word per setup
// Assumes: single write port, single read port, same clock
// Notes: read data comes out of a register one edge after rd_en
`timescale 1ns/10ps
module rmts_setup_mem import rmts_pkg::*; #(
	parameter int WIDTH = SETUP_W,
	parameter int DEPTH = SETUP_DEPTH,
	parameter int AW = PTR_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge mclk) begin
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem_reg[rd_addr];
		end
	end

endmodule // rmts_setup_mem

// *** pkg/rmts_pkg.sv ***
// Purpose: shared constants and types of the relay matrix trigger sequencer
// Assumes: one 100 MHz clock, relay cards and trigger logic on that clock
// Notes: times are kept in their own unit, cycle counts are derived here
package rmts_pkg;

	// Matrix geometry and setup store
	localparam int ROWS = 8;
	localparam int COLS = 12;
	localparam int ROW_IDX_W = 3;
	localparam int SETUP_W = ROWS * COLS;
	localparam int SETUP_DEPTH = 100;
	localparam int PTR_W = 7;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TICK_NS = 1000000;
	localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int XFER_TIME_NS = 1000;
	localparam int XFER_CYCLES = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XFER_CNT_W = 8;
	localparam int SYNC_STAGES = 3;

	// Programmed delay limits and reset values
	localparam int DELAY_W = 16;
	localparam logic [15:0] DELAY_MAX_MS = 16'hFDE8;
	localparam logic [15:0] DELAY_RESET_MS = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;

	// Sequencing phases, in the order they are applied
	localparam logic [1:0] PH_BM_OPEN = 2'h0;
	localparam logic [1:0] PH_MB_CLOSE = 2'h1;
	localparam logic [1:0] PH_MB_OPEN = 2'h2;
	localparam logic [1:0] PH_FINAL = 2'h3;

	typedef enum logic [1:0] {
		ROW_SEL_MB,
		ROW_SEL_BM,
		ROW_DESEL_MB,
		ROW_DESEL_BM
	} rmts_row_op_t;

	typedef enum logic {
		TRIG_SRC_EXT,
		TRIG_SRC_BUS
	} rmts_trig_src_t;

	typedef struct packed {
		logic trigger_enable_cmd;
		rmts_trig_src_t src;
		logic ext_rising;
		logic mready_high;
	} rmts_cfg_t;

	typedef struct packed {
		logic valid;
		logic [ROW_IDX_W-1:0] row;
		rmts_row_op_t op;
	} rmts_row_cmd_t;

	typedef struct packed {
		logic overrun;
		logic not_settled;
	} rmts_err_t;

	typedef struct packed {
		logic err;
		logic matrix_ready;
		logic ready;
	} rmts_poll_t;

endpackage

// *** testbench/relay_matrix_trigger_sequencer_tb.sv ***
// Purpose: self-checking bench of the trigger sequencer
// Assumes: tick shortened to 10 clocks, cards report 1 ms
// Notes: cycle figures are exact for a 10-clock tick and 100-clock transfer
`timescale 1ns/10ps
module relay_matrix_trigger_sequencer_tb import rmts_pkg::*; ;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	rmts_cfg_t cfg = '{1'b1, TRIG_SRC_BUS, 1'b0, 1'b0};
	logic delay_wr = 1'b0;
	logic [DELAY_W-1:0] delay_ms_in = 16'h0000;
	rmts_row_cmd_t row_cmd = '0;
	logic err_clear = 1'b0;
	logic mem_wr_en = 1'b0;
	logic [PTR_W-1:0] mem_wr_addr = 7'h00;
	logic [SETUP_W-1:0] mem_wr_data = '0;
	logic bus_trigger = 1'b0;
	logic external_trigger_pin, chain_err_in, relay_load_reg, matrix_ready_pin_reg, standalone_reg;
	logic [DELAY_W-1:0] hw_settle_ms_in, machine_status_query_reg, hw_settle_query_reg;
	logic [SETUP_W-1:0] relay_setup_reg;
	logic [ROWS-1:0] mb_rows_reg, bm_rows_reg;
	rmts_poll_t poll_status_reg;
	rmts_err_t error_cause_query_reg;
	logic [PTR_W-1:0] step_ptr_reg;
	int n_mismatch = 0;
	int cmp_count = 0;
	int loads, cyc, ep;
	rmts_sequencer #(.TICK_CYCLES(10)) dut_u (.mclk, .rst, .cfg, .delay_wr, .delay_ms_in,
		.row_cmd, .err_clear, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .bus_trigger,
		.external_trigger_pin, .hw_settle_ms_in, .chain_err_in, .relay_setup_reg,
		.relay_load_reg, .mb_rows_reg, .bm_rows_reg, .matrix_ready_pin_reg, .poll_status_reg,
		.error_cause_query_reg, .machine_status_query_reg, .hw_settle_query_reg,
		.step_ptr_reg, .standalone_reg);
	rmts_card_model card_u (.mclk, .hw_settle_ms_in, .chain_err_in, .external_trigger_pin);
	always #5 mclk = ~mclk;
	function automatic logic [SETUP_W-1:0] pat(input int i);
		return {4{24'(i * 24'h5A3C71)}};
	endfunction
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic pulse_bus;
		@(negedge mclk);
		bus_trigger = 1'b1;
		@(negedge mclk);
		bus_trigger = 1'b0;
	endtask
	// Counts loads and clocks until ready has dropped and returned
	task automatic wait_ready;
		bit low;
		low = 0;
		loads = 0;
		for (cyc = 0; cyc < 3000 && !(low && poll_status_reg.ready === 1'b1); cyc++) begin
			@(negedge mclk);
			low |= poll_status_reg.ready === 1'b0;
			loads += relay_load_reg;
		end
		chk(cyc < 3000, 1);
	endtask
	task automatic fire(input bit ext);
		if (ext)
			card_u.pulse();
		else
			pulse_bus();
		wait_ready();
	endtask
	task automatic row(input logic [2:0] r, input rmts_row_op_t op);
		@(negedge mclk);
		row_cmd = '{1'b1, r, op};
		@(negedge mclk);
		row_cmd.valid = 1'b0;
	endtask
	task automatic put_delay(input logic [DELAY_W-1:0] v);
		@(negedge mclk);
		delay_wr = 1'b1;
		delay_ms_in = v;
		@(negedge mclk);
		delay_wr = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic clear_err;
		@(negedge mclk);
		err_clear = 1'b1;
		@(negedge mclk);
		err_clear = 1'b0;
		chk(error_cause_query_reg, 2'b00);
	endtask
	// Row mixes in turn: none, MB, both, BM, none
	task automatic t_rows;
		int nl[5] = '{1, 2, 4, 2, 1};
		int base;
		for (int i = 0; i < 5; i++) begin
			if (i > 0)
				row(3'((i - 1) % 2), rmts_row_op_t'(i - 1));
			fire(0);
			if (i == 0)
				base = cyc;
			ep++;
			chk(loads, nl[i]);
			// Extra phase: transfer, 1 ms settle of 10 clocks, one clock to see it end
			chk(cyc - base, (XFER_CYCLES + 11) * (nl[i] - 1));
			chk(relay_setup_reg, pat(ep));
			chk(step_ptr_reg, ep);
		end
		chk(base >= 110 && base <= 114, 1);
		row(3'h2, ROW_SEL_MB);
		row(3'h2, ROW_SEL_BM);
		chk({mb_rows_reg, bm_rows_reg}, 16'h0004);
		row(3'h2, ROW_DESEL_BM);
		chk(bm_rows_reg, 0);
	endtask
	task automatic t_settle;
		put_delay(16'hFDE8);
		put_delay(16'hFDE9);
		chk(machine_status_query_reg, 16'hFDE8);
		put_delay(16'h0002);
		fire(0);
		ep++;
		chk(cyc, 114 + 2 * 10);
		chk(relay_setup_reg, pat(ep));
		chk(matrix_ready_pin_reg, 0);
		pulse_bus();
		repeat (120) @(negedge mclk);
		pulse_bus();
		repeat (3) @(negedge mclk);
		ep += 2;
		chk(error_cause_query_reg, 2'b01);
		chk(step_ptr_reg, ep);
		wait_ready();
		clear_err();
		pulse_bus();
		repeat (30) @(negedge mclk);
		pulse_bus();
		repeat (3) @(negedge mclk);
		ep++;
		chk({error_cause_query_reg, poll_status_reg.err}, 3'b101);
		chk(step_ptr_reg, ep);
		wait_ready();
		clear_err();
	endtask
	task automatic t_ext;
		for (int e = 0; e < 2; e++) begin
			cfg = '{1'b1, TRIG_SRC_EXT, e[0], 1'b1};
			fire(1);
			ep++;
			chk(step_ptr_reg, ep);
			chk({matrix_ready_pin_reg, poll_status_reg}, 4'hB);
		end
		cfg = '{1'b1, TRIG_SRC_BUS, 1'b0, 1'b1};
		card_u.pulse();
		cfg.trigger_enable_cmd = 1'b0;
		pulse_bus();
		repeat (6) @(negedge mclk);
		chk(step_ptr_reg, ep);
	endtask
	initial begin
		#300000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		ep = 0;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		mem_wr_en = 1'b1;
		for (int i = 1; i < 12; i++) begin
			mem_wr_addr = 7'(i);
			mem_wr_data = pat(i);
			@(negedge mclk);
		end
		mem_wr_en = 1'b0;
		chk(hw_settle_query_reg, 1);
		chk({matrix_ready_pin_reg, poll_status_reg}, 4'h9);
		t_rows();
		t_settle();
		t_ext();
		card_u.set_chain(1'b1);
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk({standalone_reg, step_ptr_reg, machine_status_query_reg}, 24'h800000);
		wrap_up();
	end
endmodule // relay_matrix_trigger_sequencer_tb
bind rmts_sequencer rmts_monitor mon_u (.mclk, .rst, .cfg, .delay_wr, .relay_load_reg,
	.mb_rows_reg, .bm_rows_reg, .matrix_ready_pin_reg, .poll_status_reg,
	.error_cause_query_reg, .machine_status_query_reg, .hw_settle_query_reg, .step_ptr_reg);

// *** testbench/rmts_card_model.sv ***
// Purpose: relay cards and external trigger source
// Assumes: trigger pin idles high
// Notes: pulse is two clocks low so either edge fires once
`timescale 1ns/10ps
module rmts_card_model import rmts_pkg::*; (
	// Clock
	input wire logic mclk,
	// Card and trigger side
	output logic [DELAY_W-1:0] hw_settle_ms_in,
	output logic chain_err_in,
	output logic external_trigger_pin
);
	initial begin
		hw_settle_ms_in = 16'h0001;
		chain_err_in = 1'b0;
		external_trigger_pin = 1'b1;
	end
	task automatic set_chain(input logic e);
		chain_err_in = e;
	endtask
	// Falling leading edge, rising trailing edge
	task automatic pulse;
		@(negedge mclk);
		external_trigger_pin = 1'b0;
		repeat (2) @(negedge mclk);
		external_trigger_pin = 1'b1;
	endtask
endmodule // rmts_card_model

// *** testbench/rmts_monitor.sv ***
// Purpose: port checker of the trigger sequencer
// Assumes: one clock, asynchronous reset
// Notes: transfer length is judged by a cycle counter
`timescale 1ns/10ps
module rmts_monitor import rmts_pkg::*; (
	// Clock, reset, inputs
	input wire logic mclk,
	input wire logic rst,
	input wire rmts_cfg_t cfg,
	input wire logic delay_wr,
	// Outputs
	input wire logic relay_load_reg,
	input wire logic [ROWS-1:0] mb_rows_reg,
	input wire logic [ROWS-1:0] bm_rows_reg,
	input wire logic matrix_ready_pin_reg,
	input wire rmts_poll_t poll_status_reg,
	input wire rmts_err_t error_cause_query_reg,
	input wire logic [DELAY_W-1:0] machine_status_query_reg,
	input wire logic [DELAY_W-1:0] hw_settle_query_reg,
	input wire logic [PTR_W-1:0] step_ptr_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] since_load;
	// Saturates so a long idle never wraps
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			since_load <= 8'hFF;
		else if (relay_load_reg)
			since_load <= 8'h00;
		else if (since_load != 8'hFF)
			since_load <= since_load + 8'h01;
	end
	ptr_step_a: assert property (
		$changed(step_ptr_reg) |-> step_ptr_reg == ($past(step_ptr_reg) == 7'h63 ? 7'h00
		: $past(step_ptr_reg) + 7'h01)) else $error("pointer step");
	load_follows_a: assert property (
		$changed(step_ptr_reg) |-> ##[1:3] relay_load_reg) else $error("no load");
	ready_low_a: assert property (
		relay_load_reg |-> !poll_status_reg.ready) else $error("ready during load");
	xfer_len_a: assert property (
		$rose(poll_status_reg.ready) |-> since_load >= XFER_CYCLES) else $error("short xfer");
	pin_pol_a: assert property (
		!$past(rst) |-> matrix_ready_pin_reg
		== (poll_status_reg.matrix_ready == $past(cfg.mready_high)))
		else $error("pin polarity");
	delay_max_a: assert property (
		machine_status_query_reg <= DELAY_MAX_MS) else $error("delay range");
	delay_hold_a: assert property (
		$changed(machine_status_query_reg) |-> $past(delay_wr) || $past(delay_wr, 2)
		|| $past(delay_wr, 3)) else $error("delay changed");
	overrun_err_a: assert property (
		$rose(error_cause_query_reg.overrun) |-> ##[0:1] poll_status_reg.err)
		else $error("err bit");
	row_excl_a: assert property (
		(mb_rows_reg & bm_rows_reg) == 8'h00) else $error("row modes");
	settle_fix_a: assert property (
		!$past(rst, 3) |-> $stable(hw_settle_query_reg)) else $error("settle moved");
	cover property ($rose(error_cause_query_reg.overrun));
	cover property ($rose(error_cause_query_reg.not_settled));
	cover property (relay_load_reg && mb_rows_reg != 8'h00 && bm_rows_reg != 8'h00);
endmodule // rmts_monitor
